// file: logic/mode_power_defs.svh
// Constants for the read channel mode and power control block.
// Assumes inclusion by bare name from logic/ files only.
`ifndef MODE_POWER_DEFS_SVH
`define MODE_POWER_DEFS_SVH
`define PDC_BIT_PULSE 0
`define PDC_BIT_SERVO 1
`define PDC_BIT_FILTER 2
`define PDC_BIT_SEP 3
`define PDC_BIT_SYNTH 4
`define PDC_FIXED_HI 3'h7
`define PDC_RESET 8'hE0
`define PLL_WRITE_DIV 6'h1E
`define REF_IDLE_DIV 6'h03
`define MARK_COUNT 2'h2
`define PREAMBLE_GROUPS 2'h3
`define PREAMBLE_3T_BITS 6'h09
`define MARK_BITS 6'h27
`define MARK_PATTERN 39'h80800800
`endif

// file: logic/mode_power_pkg.sv
// Types for the read channel mode and power control block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package mode_power_pkg;
    typedef enum logic [2:0] {
        MODE_SLEEP = 3'h0,
        MODE_IDLE = 3'h1,
        MODE_READ = 3'h3,
        MODE_WRITE = 3'h2,
        MODE_SERVO = 3'h6,
        MODE_TEST = 3'h7
    } chan_mode_e;
    typedef enum logic [1:0] {
        GEN_IDLE = 2'h0,
        GEN_MARK = 2'h1,
        GEN_PRE = 2'h3,
        GEN_DONE = 2'h2
    } gen_state_e;
    typedef logic [7:0] pdc_t;
endpackage
`default_nettype wire

// file: logic/mark_preamble_gen.sv
// Serialises two address marks then a 3T preamble on write window rise.
// Assumes write_gate is synchronous to clk_sys.
`default_nettype none
`include "mode_power_defs.svh"
module mark_preamble_gen (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic start,
    input wire logic enable,
    output logic bit_out,
    output logic busy
);
    import mode_power_pkg::*;
    gen_state_e state_reg, state_next;
    logic [5:0] bit_reg, bit_next;
    logic [1:0] grp_reg, grp_next;
    logic [38:0] mark_pattern;
    logic out_reg, out_next;

    assign mark_pattern = `MARK_PATTERN;
    assign bit_out = out_reg;
    // Mark and preamble codes share bit 0, so busy comes straight from a flop
    assign busy = state_reg[0];

    always_comb begin
        state_next = state_reg;
        bit_next = bit_reg;
        grp_next = grp_reg;
        out_next = 1'b0;
        unique case (state_reg)
            GEN_IDLE: begin
                if (start) begin
                    state_next = GEN_MARK;
                    bit_next = 6'h00;
                    grp_next = 2'h0;
                end
            end
            GEN_MARK: begin
                // MSB first: 7 zeros, 1, 7 zeros, 1, 11 zeros, 1, 11 zeros
                out_next = mark_pattern[6'd38 - bit_reg];
                if (bit_reg == `MARK_BITS - 6'h01) begin
                    bit_next = 6'h00;
                    if (grp_reg == `MARK_COUNT - 2'h1) begin
                        grp_next = 2'h0;
                        state_next = GEN_PRE;
                    end else begin
                        grp_next = grp_reg + 2'h1;
                    end
                end else begin
                    bit_next = bit_reg + 6'h01;
                end
            end
            GEN_PRE: begin
                // Three 3T groups, each 100 repeated three times
                out_next = (bit_reg == 6'h00) || (bit_reg == 6'h03) || (bit_reg == 6'h06);
                if (bit_reg == `PREAMBLE_3T_BITS - 6'h01) begin
                    bit_next = 6'h00;
                    if (grp_reg == `PREAMBLE_GROUPS - 2'h1) begin
                        state_next = GEN_DONE;
                    end else begin
                        grp_next = grp_reg + 2'h1;
                    end
                end else begin
                    bit_next = bit_reg + 6'h01;
                end
            end
            GEN_DONE: begin
                if (!start) begin
                    state_next = GEN_DONE;
                end
            end
        endcase
        // Falling write window aborts any run in progress
        if (!enable) begin
            state_next = GEN_IDLE;
            out_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= GEN_IDLE;
            bit_reg <= 6'h00;
            grp_reg <= 2'h0;
            out_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            bit_reg <= bit_next;
            grp_reg <= grp_next;
            out_reg <= out_next;
        end
    end
endmodule
`default_nettype wire

// file: logic/read_channel_mode_power_control.sv
// Mode decode and power enables for the read channel, plus write preamble.
// Assumes gates, sleep and register load strobe are synchronous to clk_sys.
`default_nettype none
`include "mode_power_defs.svh"
module read_channel_mode_power_control (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic write_gate,
    input wire logic read_gate,
    input wire logic servo_gate,
    input wire logic global_sleep_n,
    input wire logic pdc_load,
    input wire mode_power_pkg::pdc_t pdc_wdata,
    input wire logic mark_seen,
    output mode_power_pkg::pdc_t power_down_control,
    output mode_power_pkg::chan_mode_e chan_mode,
    output logic pulse_detect_on,
    output logic servo_demod_on,
    output logic filter_on,
    output logic data_sep_on,
    output logic data_sep_write_only,
    output logic synth_on,
    output logic inputs_shorted,
    output logic fast_acquire,
    output logic write_nrz_in_enable,
    output logic read_nrz_out_oe_n,
    output logic mark_found,
    output logic mark_found_oe_n,
    output logic pulse_data_oe_n,
    output logic gain_hold_enable,
    output logic [5:0] pll_ref_div,
    output logic pll_lock_to_synth,
    output logic [5:0] read_ref_div,
    output logic mark_search,
    output logic write_data,
    output logic write_preamble_busy
);
    import mode_power_pkg::*;

    // Register group
    pdc_t pdc_reg, pdc_next;
    // Gate history group
    logic wg_prev_reg, wg_prev_next;
    logic rg_prev_reg, rg_prev_next;
    // Mode and power enable group
    chan_mode_e mode_reg, mode_next;
    logic pd_on_reg, pd_on_next;
    logic sd_on_reg, sd_on_next;
    logic flt_on_reg, flt_on_next;
    logic ds_on_reg, ds_on_next;
    logic dsw_reg, dsw_next;
    logic fs_on_reg, fs_on_next;
    // Pin control group
    logic short_reg, short_next;
    logic fast_reg, fast_next;
    logic wr_en_reg, wr_en_next;
    logic rd_oe_n_reg, rd_oe_n_next;
    logic mf_reg, mf_next;
    logic mf_oe_n_reg, mf_oe_n_next;
    logic pdat_oe_n_reg, pdat_oe_n_next;
    logic hold_reg, hold_next;
    // Clock selection and mark search group
    logic [5:0] pll_div_reg, pll_div_next;
    logic [5:0] rref_div_reg, rref_div_next;
    logic lock_reg, lock_next;
    logic search_reg, search_next;
    // Generator and decode helpers
    logic gen_bit, gen_busy, gen_start;
    logic bits_clear, test_bits, filter_test;
    logic wr_pat, rd_pat, idle_pat, servo_pat;

    assign gen_start = write_gate && !wg_prev_reg && global_sleep_n;

    mark_preamble_gen u_gen (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(gen_start),
        .enable(write_gate && global_sleep_n),
        .bit_out(gen_bit),
        .busy(gen_busy)
    );

    always_comb begin
        pdc_next = pdc_reg;
        if (pdc_load) begin
            // Upper three bits cannot be written
            pdc_next = {`PDC_FIXED_HI, pdc_wdata[4:0]};
        end
    end

    always_comb begin
        bits_clear = (pdc_reg[4:0] == 5'h00);
        test_bits = (pdc_reg[4:0] == 5'h07);
        filter_test = (pdc_reg[4:0] == 5'h1B);
        wr_pat = write_gate && !read_gate && servo_gate;
        rd_pat = !write_gate && read_gate && servo_gate;
        idle_pat = !write_gate && !read_gate && servo_gate;
        servo_pat = !write_gate && !servo_gate;

        // Default: each block follows its own bit, inverted: set means powered down
        pd_on_next = !pdc_reg[`PDC_BIT_PULSE];
        sd_on_next = !pdc_reg[`PDC_BIT_SERVO];
        flt_on_next = !pdc_reg[`PDC_BIT_FILTER];
        ds_on_next = !pdc_reg[`PDC_BIT_SEP];
        fs_on_next = !pdc_reg[`PDC_BIT_SYNTH];
        dsw_next = 1'b0;
        short_next = 1'b0;
        fast_next = 1'b0;
        wr_en_next = 1'b0;
        rd_oe_n_next = 1'b1;
        mf_next = 1'b1;
        mf_oe_n_next = 1'b0;
        pdat_oe_n_next = 1'b0;
        hold_next = 1'b0;
        pll_div_next = `REF_IDLE_DIV;
        rref_div_next = `REF_IDLE_DIV;
        lock_next = 1'b0;
        search_next = 1'b0;
        mode_next = MODE_TEST;

        if (!global_sleep_n) begin
            // Only the serial port survives sleep
            mode_next = MODE_SLEEP;
            pd_on_next = 1'b0;
            sd_on_next = 1'b0;
            flt_on_next = 1'b0;
            ds_on_next = 1'b0;
            fs_on_next = 1'b0;
            mf_oe_n_next = 1'b1;
            pdat_oe_n_next = 1'b1;
        end else if (bits_clear && wr_pat) begin
            mode_next = MODE_WRITE;
            pd_on_next = 1'b0;
            sd_on_next = 1'b0;
            flt_on_next = 1'b0;
            wr_en_next = 1'b1;
            mf_oe_n_next = 1'b1;
            pdat_oe_n_next = 1'b1;
            short_next = 1'b1;
            pll_div_next = `PLL_WRITE_DIV;
        end else if (bits_clear && idle_pat) begin
            mode_next = MODE_IDLE;
            lock_next = 1'b1;
            hold_next = 1'b1;
        end else if (bits_clear && rd_pat) begin
            mode_next = MODE_READ;
            hold_next = 1'b1;
            // Mark search armed on read window rise, held until found
            search_next = (read_gate && !rg_prev_reg) || (search_reg && !mark_seen);
            mf_next = !mark_seen;
        end else if (servo_pat && (bits_clear || pdc_reg[4:0] == 5'h18)) begin
            // Separator and synth follow their bits here
            mode_next = MODE_SERVO;
            lock_next = bits_clear;
        end else if (filter_test) begin
            // Gates ignored; only filter path stays up
            pdat_oe_n_next = 1'b1;
        end else if (test_bits && rd_pat) begin
            pdat_oe_n_next = 1'b1;
        end else if (test_bits && wr_pat) begin
            dsw_next = 1'b1;
            pdat_oe_n_next = 1'b1;
        end else if (test_bits) begin
            ds_on_next = 1'b0;
            pdat_oe_n_next = 1'b1;
        end

        // Fast acquisition pulse on leaving write
        if (wg_prev_reg && !write_gate && global_sleep_n) begin
            fast_next = 1'b1;
        end
    end

    // Gate history; resets low like the gates, so no false edge follows reset
    always_comb begin
        wg_prev_next = write_gate;
        rg_prev_next = read_gate;
    end

    // Fixed upper bits come back with reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pdc_reg <= `PDC_RESET;
        end else begin
            pdc_reg <= pdc_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wg_prev_reg <= 1'b0;
            rg_prev_reg <= 1'b0;
        end else begin
            wg_prev_reg <= wg_prev_next;
            rg_prev_reg <= rg_prev_next;
        end
    end

    // All decoded outputs registered once: one clock of latency
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= MODE_SLEEP;
            pd_on_reg <= 1'b0;
            sd_on_reg <= 1'b0;
            flt_on_reg <= 1'b0;
            ds_on_reg <= 1'b0;
            dsw_reg <= 1'b0;
            fs_on_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            pd_on_reg <= pd_on_next;
            sd_on_reg <= sd_on_next;
            flt_on_reg <= flt_on_next;
            ds_on_reg <= ds_on_next;
            dsw_reg <= dsw_next;
            fs_on_reg <= fs_on_next;
        end
    end

    // Pins float and the mark flag idles high while in reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            short_reg <= 1'b0;
            fast_reg <= 1'b0;
            wr_en_reg <= 1'b0;
            rd_oe_n_reg <= 1'b1;
            mf_reg <= 1'b1;
            mf_oe_n_reg <= 1'b1;
            pdat_oe_n_reg <= 1'b1;
            hold_reg <= 1'b0;
        end else begin
            short_reg <= short_next;
            fast_reg <= fast_next;
            wr_en_reg <= wr_en_next;
            rd_oe_n_reg <= rd_oe_n_next;
            mf_reg <= mf_next;
            mf_oe_n_reg <= mf_oe_n_next;
            pdat_oe_n_reg <= pdat_oe_n_next;
            hold_reg <= hold_next;
        end
    end

    // Clock selection and mark search
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pll_div_reg <= `REF_IDLE_DIV;
            rref_div_reg <= `REF_IDLE_DIV;
            lock_reg <= 1'b0;
            search_reg <= 1'b0;
        end else begin
            pll_div_reg <= pll_div_next;
            rref_div_reg <= rref_div_next;
            lock_reg <= lock_next;
            search_reg <= search_next;
        end
    end

    assign power_down_control = pdc_reg;
    assign chan_mode = mode_reg;
    assign pulse_detect_on = pd_on_reg;
    assign servo_demod_on = sd_on_reg;
    assign filter_on = flt_on_reg;
    assign data_sep_on = ds_on_reg;
    assign data_sep_write_only = dsw_reg;
    assign synth_on = fs_on_reg;
    assign inputs_shorted = short_reg;
    assign fast_acquire = fast_reg;
    assign write_nrz_in_enable = wr_en_reg;
    assign read_nrz_out_oe_n = rd_oe_n_reg;
    assign mark_found = mf_reg;
    assign mark_found_oe_n = mf_oe_n_reg;
    assign pulse_data_oe_n = pdat_oe_n_reg;
    assign gain_hold_enable = hold_reg;
    assign pll_ref_div = pll_div_reg;
    assign pll_lock_to_synth = lock_reg;
    assign read_ref_div = rref_div_reg;
    assign mark_search = search_reg;
    // Controller must keep write data low meanwhile
    assign write_data = gen_bit;
    assign write_preamble_busy = gen_busy;
endmodule
`default_nettype wire

// file: verif/mode_power_props.sv
// Checker for mode decode, write pattern and power enables.
// Assumes binding to the top module; one clock domain.
`default_nettype none
module mode_power_props
    import mode_power_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic write_gate,
    input wire logic read_gate,
    input wire logic servo_gate,
    input wire logic global_sleep_n,
    input wire mode_power_pkg::pdc_t power_down_control,
    input wire mode_power_pkg::chan_mode_e chan_mode,
    input wire logic pulse_detect_on,
    input wire logic servo_demod_on,
    input wire logic filter_on,
    input wire logic data_sep_on,
    input wire logic synth_on,
    input wire logic inputs_shorted,
    input wire logic fast_acquire,
    input wire logic write_nrz_in_enable,
    input wire logic mark_found_oe_n,
    input wire logic pulse_data_oe_n,
    input wire logic gain_hold_enable,
    input wire logic [5:0] pll_ref_div,
    input wire logic mark_search,
    input wire logic write_data,
    input wire logic write_preamble_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire logic clr = global_sleep_n && power_down_control[4:0] == 5'h00;
    wire logic [4:0] en = {synth_on, data_sep_on, filter_on, servo_demod_on, pulse_detect_on};
    AST_SLEEP: assert property (!global_sleep_n |=> en == 5'h00) else $error("block on in sleep");
    AST_FIXED: assert property (power_down_control[7:5] == 3'h7) else $error("fixed bits lost");
    AST_WRITE: assert property (clr && write_gate && !read_gate && servo_gate |=>
        inputs_shorted && write_nrz_in_enable && mark_found_oe_n && pll_ref_div == 6'h1E) else $error("write decode");
    AST_IDLE: assert property (clr && !write_gate && !read_gate && servo_gate |=>
        en == 5'h1F && gain_hold_enable && !mark_found_oe_n && !pulse_data_oe_n) else $error("idle decode");
    AST_SERVO: assert property (clr && !write_gate && !servo_gate |=>
        en == 5'h1F && !gain_hold_enable && !pulse_data_oe_n) else $error("servo decode");
    AST_SERVO_LOW: assert property (global_sleep_n && power_down_control[4:0] == 5'h18
        && !write_gate && !servo_gate |=> en == 5'h07) else $error("servo low power decode");
    AST_READ: assert property (clr && $rose(read_gate) && !write_gate && servo_gate |=>
        mark_search && gain_hold_enable) else $error("read decode");
    AST_READ_HOLD: assert property (clr && !write_gate && read_gate && servo_gate |=>
        gain_hold_enable && !mark_found_oe_n) else $error("read hold decode");
    AST_FAST: assert property ($fell(write_gate) && chan_mode == MODE_WRITE |=>
        fast_acquire && !inputs_shorted ##1 !fast_acquire) else $error("write end");
    AST_MARK: assert property ($rose(write_preamble_busy) |=>
        !write_data [*7] ##1 write_data ##1 !write_data [*7] ##1 write_data) else $error("mark start");
endmodule
bind read_channel_mode_power_control mode_power_props props (.clk_sys, .rst_n, .write_gate, .read_gate,
    .servo_gate, .global_sleep_n, .power_down_control, .chan_mode, .pulse_detect_on, .servo_demod_on,
    .filter_on, .data_sep_on, .synth_on, .inputs_shorted, .fast_acquire, .write_nrz_in_enable,
    .mark_found_oe_n, .pulse_data_oe_n, .gain_hold_enable, .pll_ref_div, .mark_search, .write_data,
    .write_preamble_busy);
`default_nettype wire

// file: verif/disk_ctl_model.sv
// Controller model: turns a requested mode into gate and sleep levels.
// Assumes requests change just after a clk_sys edge.
`default_nettype none
module disk_ctl_model
    import mode_power_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire mode_power_pkg::chan_mode_e want,
    input wire logic busy,
    output logic write_gate,
    output logic read_gate,
    output logic servo_gate,
    output logic global_sleep_n,
    output logic write_nrz
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sent;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {write_gate, read_gate, servo_gate, global_sleep_n, sent} <= 5'h00;
        end else if (want == MODE_WRITE && !global_sleep_n) begin
            // Pass through idle; sleep straight to write is illegal
            {write_gate, read_gate, servo_gate, global_sleep_n} <= 4'h3;
        end else begin
            global_sleep_n <= want != MODE_SLEEP;
            write_gate <= want == MODE_WRITE;
            read_gate <= want == MODE_READ;
            servo_gate <= want != MODE_SERVO;
            sent <= write_gate && (sent || busy);
        end
    end
    // Held at zero until the pattern is out
    assign write_nrz = sent && !busy;
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Testbench: walks modes and register loads, checks decode and pattern.
// Assumes the controller model drives gates and sleep.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mode_power_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic pdc_load = 1'b0;
    pdc_t pdc_wdata = 8'h00;
    logic mark_seen = 1'b0;
    chan_mode_e want = MODE_SLEEP;
    wire logic write_gate, read_gate, servo_gate, global_sleep_n;
    pdc_t power_down_control;
    chan_mode_e chan_mode;
    logic pulse_detect_on, servo_demod_on, filter_on, data_sep_on, data_sep_write_only, synth_on;
    logic inputs_shorted, fast_acquire, write_nrz_in_enable, read_nrz_out_oe_n, mark_found;
    logic mark_found_oe_n, pulse_data_oe_n, gain_hold_enable, pll_lock_to_synth, mark_search;
    logic write_data, write_preamble_busy;
    logic [5:0] pll_ref_div, read_ref_div;
    int err_count = 0;
    int n_tests = 0;
    int k;
    wire logic [7:0] en = {3'h0, synth_on, data_sep_on, filter_on, servo_demod_on, pulse_detect_on};
    localparam logic [104:0] exp_w = {39'h80800800, 39'h80800800, 27'h4924924};
    read_channel_mode_power_control dut (.clk_sys, .rst_n, .write_gate, .read_gate, .servo_gate,
        .global_sleep_n, .pdc_load, .pdc_wdata, .mark_seen, .power_down_control, .chan_mode,
        .pulse_detect_on, .servo_demod_on, .filter_on, .data_sep_on, .data_sep_write_only, .synth_on,
        .inputs_shorted, .fast_acquire, .write_nrz_in_enable, .read_nrz_out_oe_n, .mark_found,
        .mark_found_oe_n, .pulse_data_oe_n, .gain_hold_enable, .pll_ref_div, .pll_lock_to_synth,
        .read_ref_div, .mark_search, .write_data, .write_preamble_busy);
    disk_ctl_model ctl (.clk_sys, .rst_n, .want, .busy(write_preamble_busy), .write_gate, .read_gate,
        .servo_gate, .global_sleep_n, .write_nrz());
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic tick(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic load(pdc_t v);
        @(posedge clk_sys);
        pdc_load <= 1'b1;
        pdc_wdata <= v;
        @(posedge clk_sys);
        pdc_load <= 1'b0;
        tick(3);
    endtask
    task automatic go(chan_mode_e m);
        @(posedge clk_sys);
        want <= m;
        tick(4);
    endtask
    task automatic test_done();
        if (err_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        chk("pdc", 8'hE0, power_down_control);
        rst_n <= 1'b1;
        tick(3);
        chk("en", 8'h00, en);
        load(8'hFF);
        chk("pdc", 8'hFF, power_down_control);
        load(8'h00);
        chk("pdc", 8'hE0, power_down_control);
        go(MODE_IDLE);
        chk("en", 8'h1F, en);
        chk("mode", MODE_IDLE, chan_mode);
        chk("ref_div", 8'h03, read_ref_div);
        chk("lock", 1'b1, pll_lock_to_synth);
        chk("nrz_oe_n", 1'b1, read_nrz_out_oe_n);
        chk("mark_found", 1'b1, mark_found);
        for (k = 0; k < 5; k++) begin
            load(8'h01 << k);
            chk("en", 8'h1F ^ (8'h01 << k), en);
        end
        load(8'h00);
        go(MODE_SERVO);
        chk("gain_hold", 1'b0, gain_hold_enable);
        load(8'h18);
        chk("en", 8'h07, en);
        load(8'h00);
        go(MODE_READ);
        chk("search", 1'b1, mark_search);
        @(posedge clk_sys);
        mark_seen <= 1'b1;
        tick(3);
        chk("mark_found", 1'b0, mark_found);
        chk("search", 1'b0, mark_search);
        load(8'h07);
        chk("en", 8'h18, en);
        chk("pulse_oe_n", 1'b1, pulse_data_oe_n);
        load(8'h1B);
        chk("en", 8'h04, en);
        go(MODE_IDLE);
        load(8'h07);
        chk("en", 8'h10, en);
        go(MODE_WRITE);
        chk("sep_write", 1'b1, data_sep_write_only);
        chk("synth", 1'b1, synth_on);
        tick(110);
        go(MODE_IDLE);
        load(8'h00);
        @(posedge clk_sys);
        want <= MODE_WRITE;
        for (k = 0; k < 20 && write_preamble_busy !== 1'b1; k++) tick(1);
        if (k == 20) begin
            err_count++;
            test_done();
        end
        for (k = 104; k >= 0; k--) begin
            tick(1);
            chk("write_data", exp_w[k], write_data);
        end
        chk("found_oe_n", 1'b1, mark_found_oe_n);
        chk("front", 8'h00, en & 8'h07);
        chk("nrz_in_en", 1'b1, write_nrz_in_enable);
        chk("mode", MODE_WRITE, chan_mode);
        chk("pll_div", 8'h1E, pll_ref_div);
        @(posedge clk_sys);
        want <= MODE_IDLE;
        for (k = 0; k < 8 && fast_acquire !== 1'b1; k++) tick(1);
        chk("fast", 1'b1, fast_acquire);
        chk("shorted", 1'b0, inputs_shorted);
        go(MODE_SLEEP);
        chk("en", 8'h00, en);
        test_done();
    end
endmodule
`default_nettype wire
